// >>> logic/hv_pkg.sv
// Constants, carrier types and behaviour list of the HV channel control
// Behaviour
// RQ1 - Manual control ramps toward the potentiometer setpoint at 500 V/s.
// RQ2 - Serial-to-manual switch uses hardware ramp toward potentiometer.
// RQ3 - Computer mode enables output only after the start command; the code also starts it on a manual-to-computer switch.
// RQ4 - Saved resume flag starts output at power-up from saved parameters.
// RQ5 - Manual-to-computer switch loads setpoint with last manual level.
// RQ6 - Computer mode ramps at programmable 2..255 V/s up to the limit.
// RQ7 - Host programs a per-channel current trip in first range units.
// RQ8 - Current above trip latches output off until restore sequence.
// RQ9 - Restore after trip: status read then start; resume needs read only.
// RQ10 - Voltage and current limits come from 10% rotary steps, 10 full.
// RQ11 - Error indicator is on while voltage or current exceeds limits.
// RQ12 - Hard shutdown cuts and latches on over-current or active inhibit.
// RQ13 - Hard shutdown clears by switch toggle or status read plus start.
// RQ14 - Limit mode clamps; inhibit cuts, release ramps back to setpoint.
// RQ15 - Polarity selector off its end positions gives no output.
// RQ16 - Computer mode setpoint drives a 16-bit converter word.
// RQ17 - Rotary limit switches are sampled several times each second.
// RQ18 - Front panel switches win over serial control requests.
// RQ19 - In manual mode commands are stored but never move the output.
// RQ20 - Ramps step the converter word at rate-sized intervals.
package hv_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned FULL_SCALE_V = 4000;
  localparam logic [8:0] HW_RAMP_V_PER_S = 9'h1f4;
  localparam logic [7:0] SW_RAMP_MIN = 8'h02;
  localparam int unsigned ACC_W = 22;
  // Accumulator wraps once per LSB; rate is added each clock
  localparam logic [63:0] RAMP_THRESH64 =
    64'(CLK_HZ) * 64'(FULL_SCALE_V) / 64'h10000;
  localparam logic [ACC_W-1:0] RAMP_THRESH = RAMP_THRESH64[ACC_W-1:0];
  localparam int unsigned LIMIT_SAMPLE_MS = 200;
  localparam int unsigned LIMIT_SAMPLE_CYCLES =
    CLK_HZ / 1000 * LIMIT_SAMPLE_MS;
  localparam logic [3:0] LIMIT_FULL_STEP = 4'ha;
  localparam logic [15:0] LIMIT_STEP_LSB = 16'h199a;
  localparam logic [15:0] LIMIT_FULL = 16'hffff;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SETPOINT = 8'h04;
  localparam logic [7:0] OFS_RATE = 8'h08;
  localparam logic [7:0] OFS_TRIP = 8'h0c;
  localparam logic [7:0] OFS_COMMAND = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_LEVEL = 8'h18;
  localparam logic [7:0] OFS_LIMITS = 8'h1c;
  // Reset values
  localparam logic [15:0] SETPOINT_RST = 16'h0000;
  localparam logic [7:0] RATE_RST = 8'h02;
  localparam logic [15:0] TRIP_RST = 16'h0000;
  // Field positions
  localparam int unsigned CTRL_RESUME = 0;
  localparam int unsigned CMD_GO = 0;
  localparam int unsigned ST_ON = 0;
  localparam int unsigned ST_OFF = 1;
  localparam int unsigned ST_MAN = 2;
  localparam int unsigned ST_ERR = 3;
  localparam int unsigned ST_INH = 4;
  localparam int unsigned ST_TRP = 5;
  localparam int unsigned ST_KILL_ENA = 6;
  localparam int unsigned ST_KILLED = 7;
  localparam int unsigned ST_RISE = 8;
  localparam int unsigned ST_FALL = 9;
  localparam int unsigned ST_POL_BAD = 10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic output_on_switch;
    logic manual;
    logic hard_shutdown_switch;
    logic inhibit_n;
    logic [1:0] polarity;
    logic [3:0] voltage_step;
    logic [3:0] current_step;
  } panel_t;
endpackage

// >>> logic/hv_ramp.sv
// Rate-accumulating ramp that steps the converter word one LSB at a time
`timescale 1ns/1ns
module hv_ramp #(
  parameter int unsigned ACC_W = hv_pkg::ACC_W
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Ramp control
  input wire logic [15:0] target_i,
  input wire logic [8:0] rate_i,
  input wire logic cut_i,
  // Ramp state
  output logic [15:0] level_o,
  output logic rising_o,
  output logic falling_o
);
  logic [ACC_W-1:0] acc;
  wire [ACC_W-1:0] acc_sum = acc + ACC_W'(rate_i);
  wire step_due = acc_sum >= hv_pkg::RAMP_THRESH;
  wire [ACC_W-1:0] acc_left = acc_sum - hv_pkg::RAMP_THRESH;
  wire [15:0] next_up = level_o + 16'h0001;
  wire [15:0] next_down = level_o - 16'h0001;

  assign rising_o = level_o < target_i;
  assign falling_o = level_o > target_i;

  // Cut drops to zero at once, bypassing the slope
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      acc <= '0;
      level_o <= 16'h0000;
    end
    else if (cut_i)
    begin
      acc <= '0;
      level_o <= 16'h0000;
    end
    else if (rising_o || falling_o)
    begin
      acc <= step_due ? acc_left : acc_sum; // RQ20
      if (step_due)
        level_o <= rising_o ? next_up : next_down; // RQ20
    end
    else
      acc <= '0;
  end

  chk_step_size: assert property ( // RQ20
    @(posedge core_clk_i) disable iff (rst_i)
    !$past(cut_i) |-> (level_o == $past(level_o) ||
      level_o == $past(level_o) + 16'h0001 ||
      level_o == $past(level_o) - 16'h0001))
    else $error("ramp moved more than one step");

  chk_cut_zero: assert property ( // RQ12
    @(posedge core_clk_i) disable iff (rst_i)
    cut_i |=> level_o == 16'h0000)
    else $error("cut did not zero the level");
endmodule // hv_ramp

// >>> logic/hv_channel_output_control.sv
// HV channel output control: setpoint selection, ramps, trips and shutdown
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module hv_channel_output_control #(
  parameter int unsigned LIMIT_SAMPLE_CYCLES = hv_pkg::LIMIT_SAMPLE_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Register bus
  input wire hv_pkg::axi_req_t axi_req_i,
  output hv_pkg::axi_rsp_t axi_rsp_o,
  // Front panel pins
  input wire hv_pkg::panel_t panel_i,
  // Converter measurements and potentiometer
  input wire logic [15:0] pot_setpoint_i,
  input wire logic [15:0] meas_voltage_i,
  input wire logic [15:0] meas_current_i,
  // Saved parameters
  input wire logic saved_resume_i,
  input wire logic [15:0] saved_setpoint_i,
  input wire logic [7:0] saved_rate_i,
  // Converter drive
  output logic [15:0] dac_o,
  output logic hv_enable_o,
  output logic error_led_o
);
  localparam int PW = $bits(hv_pkg::panel_t);

  function automatic logic [15:0] step_level(input logic [3:0] step);
    logic [31:0] prod;
    prod = 32'({12'h000, step}) * 32'(hv_pkg::LIMIT_STEP_LSB);
    step_level = (step >= hv_pkg::LIMIT_FULL_STEP) ? hv_pkg::LIMIT_FULL
                                                   : prod[15:0];
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    merge = {strb[1] ? data[15:8] : old[15:8],
             strb[0] ? data[7:0] : old[7:0]};
  endfunction

  function automatic logic rd_mapped(input logic [7:0] a);
    rd_mapped = a == hv_pkg::OFS_CTRL || a == hv_pkg::OFS_SETPOINT ||
                a == hv_pkg::OFS_RATE || a == hv_pkg::OFS_TRIP ||
                a == hv_pkg::OFS_COMMAND || a == hv_pkg::OFS_STATUS ||
                a == hv_pkg::OFS_LEVEL || a == hv_pkg::OFS_LIMITS;
  endfunction

  function automatic logic wr_mapped(input logic [7:0] a);
    wr_mapped = a == hv_pkg::OFS_CTRL || a == hv_pkg::OFS_SETPOINT ||
                a == hv_pkg::OFS_RATE || a == hv_pkg::OFS_TRIP ||
                a == hv_pkg::OFS_COMMAND;
  endfunction

  // Pin synchroniser: change accepted once stages two and three agree
  logic [PW-1:0] sync1, sync2, sync3, pflt;
  wire [PW-1:0] agree = ~(sync2 ^ sync3);
  wire [PW-1:0] next_pflt = (agree & sync3) | (~agree & pflt);
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pflt <= '0;
    end
    else
    begin
      sync1 <= panel_i;
      sync2 <= sync1;
      sync3 <= sync2;
      pflt <= next_pflt;
    end
  end
  hv_pkg::panel_t pnl;
  assign pnl = hv_pkg::panel_t'(pflt);

  // Limit switches sampled periodically, not tracked continuously
  logic [31:0] sample_cnt;
  logic [15:0] vlim, ilim;
  wire sample = sample_cnt == 32'(LIMIT_SAMPLE_CYCLES - 1);
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sample_cnt <= '0;
      vlim <= 16'h0000;
      ilim <= 16'h0000;
    end
    else
    begin
      sample_cnt <= sample ? 32'h0 : sample_cnt + 32'h1; // RQ17
      if (sample)
      begin
        vlim <= step_level(pnl.voltage_step); // RQ10
        ilim <= step_level(pnl.current_step); // RQ10
      end
    end
  end

  // AXI4-Lite slave: one write and one read in flight
  logic aw_held, w_held, bvalid, rvalid;
  logic [7:0] aw_addr;
  logic [31:0] w_data, rdata;
  logic [3:0] w_strb;
  logic [1:0] bresp, rresp;
  wire aw_take = axi_req_i.awvalid && !aw_held;
  wire w_take = axi_req_i.wvalid && !w_held;
  wire wr_go = aw_held && w_held && !bvalid;
  wire ar_take = axi_req_i.arvalid && !rvalid;
  wire status_read = ar_take && axi_req_i.araddr == hv_pkg::OFS_STATUS;
  wire wr_ctrl = wr_go && aw_addr == hv_pkg::OFS_CTRL;
  wire wr_setp = wr_go && aw_addr == hv_pkg::OFS_SETPOINT;
  wire wr_rate = wr_go && aw_addr == hv_pkg::OFS_RATE;
  wire wr_trip = wr_go && aw_addr == hv_pkg::OFS_TRIP;
  wire wr_cmd = wr_go && aw_addr == hv_pkg::OFS_COMMAND && w_strb[0];
  assign axi_rsp_o = '{awready: !aw_held, wready: !w_held,
                       bvalid: bvalid, bresp: bresp,
                       arready: !rvalid, rvalid: rvalid,
                       rdata: rdata, rresp: rresp};

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= hv_pkg::RESP_OKAY;
    end
    else
    begin
      if (aw_take)
        aw_addr <= axi_req_i.awaddr;
      if (w_take)
      begin
        w_data <= axi_req_i.wdata;
        w_strb <= axi_req_i.wstrb;
      end
      aw_held <= wr_go ? 1'b0 : (aw_held || aw_take);
      w_held <= wr_go ? 1'b0 : (w_held || w_take);
      if (wr_go)
        bresp <= wr_mapped(aw_addr) ? hv_pkg::RESP_OKAY
                                    : hv_pkg::RESP_SLVERR;
      bvalid <= wr_go ? 1'b1 : (bvalid && !axi_req_i.bready);
    end
  end

  // Channel state
  logic resume, sw_running, trip_latch, kill_latch, armed;
  logic err_seen, inh_seen, was_manual, boot, on_prev, kill_prev;
  logic [15:0] setpoint, trip;
  logic [7:0] rate;
  wire [15:0] level;
  wire rising, falling;
  wire pol_ok = pnl.polarity == 2'b01 || pnl.polarity == 2'b10; // RQ15
  wire inhibit = !pnl.inhibit_n;
  wire over_i = meas_current_i > ilim;
  wire over_v = meas_voltage_i > vlim;
  wire trip_hit = trip != 16'h0000 && meas_current_i > trip; // RQ8
  wire kill_hit = pnl.hard_shutdown_switch && (over_i || inhibit); // RQ12
  wire sw_toggle = (pnl.output_on_switch != on_prev) ||
                   (pnl.hard_shutdown_switch != kill_prev); // RQ13
  // Start command is ignored while the panel selects manual
  wire go = wr_cmd && w_data[hv_pkg::CMD_GO] && !pnl.manual; // RQ19
  wire restore = (armed && go) || (status_read && resume); // RQ9
  wire takeover = was_manual && !pnl.manual; // RQ5
  wire run = pnl.output_on_switch && pol_ok && !trip_latch && // RQ18
             !kill_latch && !inhibit && (pnl.manual || sw_running); // RQ3
  wire cut = !pol_ok || trip_latch || kill_latch || inhibit; // RQ14
  wire [15:0] raw_target = pnl.manual ? pot_setpoint_i : setpoint; // RQ1
  wire [15:0] clamped = raw_target > vlim ? vlim : raw_target; // RQ14
  wire [15:0] target = run ? clamped : 16'h0000; // RQ6
  wire [7:0] sw_rate = rate < hv_pkg::SW_RAMP_MIN ? hv_pkg::SW_RAMP_MIN
                                                  : rate; // RQ6
  wire hw_ramp = pnl.manual || !pnl.output_on_switch; // RQ2
  wire [8:0] ramp_rate = hw_ramp ? hv_pkg::HW_RAMP_V_PER_S
                                 : {1'b0, sw_rate}; // RQ1

  hv_ramp #(.ACC_W(hv_pkg::ACC_W)) u_ramp (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .target_i(target),
    .rate_i(ramp_rate),
    .cut_i(cut),
    .level_o(level),
    .rising_o(rising),
    .falling_o(falling)
  );

  // Host registers; saved parameters caught one cycle after release
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      boot <= 1'b1;
      resume <= 1'b0;
      setpoint <= hv_pkg::SETPOINT_RST;
      rate <= hv_pkg::RATE_RST;
      trip <= hv_pkg::TRIP_RST;
    end
    else
    begin
      boot <= 1'b0;
      if (boot)
      begin
        resume <= saved_resume_i; // RQ4
        setpoint <= saved_setpoint_i; // RQ4
        rate <= saved_rate_i; // RQ4
      end
      else
      begin
        if (wr_ctrl && w_strb[0])
          resume <= w_data[hv_pkg::CTRL_RESUME];
        if (takeover)
          setpoint <= level; // RQ5
        else if (wr_setp)
          setpoint <= merge(setpoint, w_data, w_strb);
        if (wr_rate && w_strb[0])
          rate <= w_data[7:0]; // RQ6
        if (wr_trip)
          trip <= merge(trip, w_data, w_strb); // RQ7
      end
    end
  end

  // Latches: a new fault in the clearing cycle keeps the latch set
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sw_running <= 1'b0;
      trip_latch <= 1'b0;
      kill_latch <= 1'b0;
      armed <= 1'b0;
      err_seen <= 1'b0;
      inh_seen <= 1'b0;
      was_manual <= 1'b0;
      on_prev <= 1'b0;
      kill_prev <= 1'b0;
    end
    else
    begin
      was_manual <= pnl.manual;
      on_prev <= pnl.output_on_switch;
      kill_prev <= pnl.hard_shutdown_switch;
      if ((boot && saved_resume_i) || go || takeover)
        sw_running <= 1'b1; // RQ3
      trip_latch <= trip_hit || (trip_latch && !restore); // RQ8
      kill_latch <= kill_hit ||
                    (kill_latch && !restore && !sw_toggle); // RQ13
      armed <= (status_read && (trip_latch || kill_latch)) ||
               (armed && !go && (trip_latch || kill_latch)); // RQ9
      err_seen <= over_v || over_i || (err_seen && !status_read);
      inh_seen <= inhibit || (inh_seen && !status_read);
    end
  end

  logic [15:0] status_word;
  always_comb
  begin
    status_word = 16'h0000;
    status_word[hv_pkg::ST_ON] = run && level == target;
    status_word[hv_pkg::ST_OFF] = !pnl.output_on_switch;
    status_word[hv_pkg::ST_MAN] = pnl.manual;
    status_word[hv_pkg::ST_ERR] = err_seen;
    status_word[hv_pkg::ST_INH] = inh_seen;
    status_word[hv_pkg::ST_TRP] = trip_latch;
    status_word[hv_pkg::ST_KILL_ENA] = pnl.hard_shutdown_switch;
    status_word[hv_pkg::ST_KILLED] = kill_latch;
    status_word[hv_pkg::ST_RISE] = rising;
    status_word[hv_pkg::ST_FALL] = falling;
    status_word[hv_pkg::ST_POL_BAD] = !pol_ok;
  end

  wire [7:0] ra = axi_req_i.araddr;
  wire [15:0] rd_word =
    ra == hv_pkg::OFS_CTRL ? {15'h0000, resume} :
    ra == hv_pkg::OFS_SETPOINT ? setpoint :
    ra == hv_pkg::OFS_RATE ? {8'h00, rate} :
    ra == hv_pkg::OFS_TRIP ? trip :
    ra == hv_pkg::OFS_STATUS ? status_word :
    ra == hv_pkg::OFS_LEVEL ? level :
    ra == hv_pkg::OFS_LIMITS ? {vlim[15:8], ilim[15:8]} : 16'h0000;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= hv_pkg::RESP_OKAY;
      hv_enable_o <= 1'b0;
      error_led_o <= 1'b0;
    end
    else
    begin
      if (ar_take)
      begin
        rdata <= {16'h0000, rd_word};
        rresp <= rd_mapped(ra) ? hv_pkg::RESP_OKAY : hv_pkg::RESP_SLVERR;
      end
      rvalid <= ar_take ? 1'b1 : (rvalid && !axi_req_i.rready);
      hv_enable_o <= run;
      error_led_o <= over_v || over_i; // RQ11
    end
  end
  assign dac_o = level; // RQ16

  chk_polarity_cut: assert property ( // RQ15
    @(posedge core_clk_i) disable iff (rst_i)
    !pol_ok |=> dac_o == 16'h0000)
    else $error("output present with polarity off its end stops");

  chk_kill_drop: assert property ( // RQ12
    @(posedge core_clk_i) disable iff (rst_i)
    kill_hit |=> kill_latch ##1 dac_o == 16'h0000)
    else $error("hard shutdown did not latch and cut");

  chk_trip_hold: assert property ( // RQ8
    @(posedge core_clk_i) disable iff (rst_i)
    trip_latch && !restore |=> trip_latch)
    else $error("trip latch released without restore");

  chk_error_led: assert property ( // RQ11
    @(posedge core_clk_i) disable iff (rst_i)
    (over_v || over_i) |=> error_led_o)
    else $error("error indicator missed a limit overrun");

  chk_takeover_load: assert property ( // RQ5
    @(posedge core_clk_i) disable iff (rst_i)
    takeover && !boot |=> setpoint == $past(level))
    else $error("setpoint not loaded from manual level");

  chk_limit_sample: assert property ( // RQ17
    @(posedge core_clk_i) disable iff (rst_i)
    $changed(vlim) || $changed(ilim) |-> $past(sample))
    else $error("limits changed outside a sample tick");

  chk_wait_start: assert property ( // RQ3
    @(posedge core_clk_i) disable iff (rst_i)
    !pnl.manual && !sw_running |=> dac_o <= $past(dac_o))
    else $error("computer mode output before start command");
endmodule // hv_channel_output_control

// >>> sim/converter_model.sv
// Converter model: measured voltage tracks the word, current follows load
`timescale 1ns/1ns
module converter_model (
  // Clock
  input wire logic core_clk_i,
  // Drive from the channel and load set by the bench
  input wire logic [15:0] dac_i,
  input wire logic [15:0] load_i,
  // Measurements
  output logic [15:0] meas_voltage_o,
  output logic [15:0] meas_current_o
);
  // One cycle of lag, like a sampled measurement path
  always_ff @(posedge core_clk_i)
  begin
    meas_voltage_o <= dac_i;
    meas_current_o <= load_i;
  end
endmodule // converter_model

// >>> sim/testbench.sv
// Self-checking bench for the HV channel output control
`timescale 1ns/1ns
module testbench;
  localparam int THR = int'(hv_pkg::RAMP_THRESH);
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  hv_pkg::axi_req_t req = '0;
  hv_pkg::axi_rsp_t rsp;
  hv_pkg::panel_t panel = {1'b1, 1'b0, 1'b0, 1'b1, 2'b01, 4'ha, 4'ha};
  logic [15:0] pot = 16'h0040;
  logic [15:0] load = 16'h0000;
  logic [15:0] mv;
  logic [15:0] mc;
  logic [15:0] dac;
  logic hv_en;
  logic err_led;
  logic resume = 1'b0;
  logic [31:0] rd;
  logic [1:0] resp;
  logic [15:0] d0;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  hv_channel_output_control #(.LIMIT_SAMPLE_CYCLES(16))
    hv_channel_output_control_i (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .axi_req_i(req),
    .axi_rsp_o(rsp), .panel_i(panel), .pot_setpoint_i(pot),
    .meas_voltage_i(mv), .meas_current_i(mc),
    .saved_resume_i(resume), .saved_setpoint_i(16'h0100),
    .saved_rate_i(8'hff), .dac_o(dac), .hv_enable_o(hv_en),
    .error_led_o(err_led));

  converter_model converter_model_i (.core_clk_i(core_clk_i),
    .dac_i(dac), .load_i(load), .meas_voltage_o(mv), .meas_current_o(mc));

  always #25 core_clk_i = ~core_clk_i;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard, well above the ~35k cycles the tests take
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      errors++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do
    begin
      @(posedge core_clk_i);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a);
    @(posedge core_clk_i);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do
    begin
      @(posedge core_clk_i);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic t_regs();
    // Saved parameters are taken at the first edge after reset
    rreg(hv_pkg::OFS_SETPOINT);
    chk("setpoint saved", 32'h0100, rd);
    rreg(hv_pkg::OFS_RATE);
    chk("rate saved", 32'hff, rd);
    rreg(hv_pkg::OFS_TRIP);
    chk("trip reset", 32'h0, rd);
    rreg(8'h20);
    chk("unmapped rresp", 32'(hv_pkg::RESP_SLVERR), 32'(resp));
    wreg(hv_pkg::OFS_STATUS, 32'h1);
    chk("status write bresp", 32'(hv_pkg::RESP_SLVERR), 32'(resp));
    rreg(hv_pkg::OFS_LIMITS);
    chk("full limits", 32'h0000ffff, rd);
    $display("test regs done");
  endtask

  task automatic t_start();
    wreg(hv_pkg::OFS_SETPOINT, 32'h0100);
    wreg(hv_pkg::OFS_RATE, 32'hff);
    repeat (40) @(posedge core_clk_i);
    chk("enable before start", 32'h0, 32'(hv_en));
    chk("dac before start", 32'h0, 32'(dac));
    wreg(hv_pkg::OFS_COMMAND, 32'h1);
    repeat (2) @(posedge core_clk_i);
    chk("enable after start", 32'h1, 32'(hv_en));
    repeat (6000) @(posedge core_clk_i);
    // 255 V/s gives one step in the first 6000 cycles
    chk("software ramp steps", 32'(6000 * 255 / THR), 32'(dac));
    rreg(hv_pkg::OFS_LEVEL);
    chk("level word", 32'(6000 * 255 / THR), rd);
    $display("test start done");
  endtask

  task automatic t_trip();
    wreg(hv_pkg::OFS_TRIP, 32'h8);
    load <= 16'h0010;
    repeat (4) @(posedge core_clk_i);
    chk("trip cuts", 32'h0, 32'(dac));
    load <= 16'h0000;
    wreg(hv_pkg::OFS_COMMAND, 32'h1);
    rreg(hv_pkg::OFS_STATUS);
    chk("trip held", 32'h1, 32'(rd[hv_pkg::ST_TRP]));
    wreg(hv_pkg::OFS_COMMAND, 32'h1);
    repeat (6000) @(posedge core_clk_i);
    chk("restored after trip", 32'h1, 32'(dac >= 16'h1));
    wreg(hv_pkg::OFS_TRIP, 32'h0);
    $display("test trip done");
  endtask

  task automatic t_kill();
    panel.hard_shutdown_switch <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    panel.inhibit_n <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    chk("kill cuts", 32'h0, 32'(dac));
    panel.inhibit_n <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    chk("kill held", 32'h0, 32'(dac));
    panel.output_on_switch <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    panel.output_on_switch <= 1'b1;
    panel.hard_shutdown_switch <= 1'b0;
    repeat (6000) @(posedge core_clk_i);
    chk("restored after toggle", 32'h1, 32'(dac >= 16'h1));
    $display("test kill done");
  endtask

  task automatic t_inhibit();
    panel.inhibit_n <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    chk("inhibit cuts", 32'h0, 32'(dac));
    panel.inhibit_n <= 1'b1;
    repeat (6000) @(posedge core_clk_i);
    chk("inhibit release ramps", 32'h1, 32'(dac >= 16'h1));
    $display("test inhibit done");
  endtask

  task automatic t_limits();
    panel.voltage_step <= 4'h5;
    panel.current_step <= 4'h0;
    repeat (40) @(posedge core_clk_i);
    rreg(hv_pkg::OFS_LIMITS);
    chk("stepped limits", 32'h00008000, rd);
    load <= 16'h0001;
    repeat (4) @(posedge core_clk_i);
    chk("error led on", 32'h1, 32'(err_led));
    load <= 16'h0000;
    repeat (4) @(posedge core_clk_i);
    chk("error led off", 32'h0, 32'(err_led));
    // Zero voltage limit pulls the ramp down to zero
    panel.voltage_step <= 4'h0;
    repeat (5000) @(posedge core_clk_i);
    chk("clamped to limit", 32'h0, 32'(dac));
    panel.voltage_step <= 4'ha;
    panel.current_step <= 4'ha;
    repeat (40) @(posedge core_clk_i);
    $display("test limits done");
  endtask

  task automatic t_manual();
    panel.manual <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    d0 = dac;
    wreg(hv_pkg::OFS_SETPOINT, 32'h0);
    wreg(hv_pkg::OFS_COMMAND, 32'h1);
    repeat (6000) @(posedge core_clk_i);
    // Accumulator phase is unknown, so two or three steps at 500 V/s
    chk("hardware ramp", 32'h1,
        32'(dac - d0 == 16'h2 || dac - d0 == 16'h3));
    panel.manual <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    d0 = dac;
    rreg(hv_pkg::OFS_SETPOINT);
    chk("setpoint takes level", 32'(d0), rd);
    $display("test manual done");
  endtask

  task automatic t_polarity();
    int n;
    panel.polarity <= 2'b11;
    repeat (8) @(posedge core_clk_i);
    rreg(hv_pkg::OFS_STATUS);
    chk("polarity flag", 32'h1, 32'(rd[hv_pkg::ST_POL_BAD]));
    n = 0;
    while (dac !== 16'h0 && n < 20000)
    begin
      @(posedge core_clk_i);
      n++;
    end
    chk("no output", 32'h0, 32'(dac));
    panel.polarity <= 2'b01;
    $display("test polarity done");
  endtask

  task automatic t_resume();
    resume <= 1'b1;
    rst_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (40) @(posedge core_clk_i);
    chk("resume enables", 32'h1, 32'(hv_en));
    wreg(hv_pkg::OFS_TRIP, 32'h8);
    load <= 16'h0010;
    repeat (4) @(posedge core_clk_i);
    chk("resume trip cuts", 32'h0, 32'(hv_en));
    load <= 16'h0000;
    repeat (2) @(posedge core_clk_i);
    // With resume set the status read alone restores the output
    rreg(hv_pkg::OFS_STATUS);
    repeat (2) @(posedge core_clk_i);
    chk("status read restores", 32'h1, 32'(hv_en));
    $display("test resume done");
  endtask

  initial
  begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_start();
    t_trip();
    t_kill();
    t_inhibit();
    t_limits();
    t_manual();
    t_polarity();
    t_resume();
    give_verdict();
  end
endmodule // testbench
